// *** src/i2c_port_pkg.sv ***
// constants, states and carriers for the two-wire slave register port
// assumes a single 125 MHz system clock and a master-driven serial clock
package i2c_port_pkg;

  // ***********************************************************
  // addressing
  // ***********************************************************
  localparam logic [7:0] ADDR_BASE    = 8'h84;
  localparam logic [4:0] TEN_PREFIX   = 5'h1e;
  localparam logic [7:0] GCALL_ADDR   = 8'h00;
  localparam logic [7:0] GC_RESET     = 8'h06;
  localparam logic [7:0] GC_LATCH     = 8'h04;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] REG_RSVD_A   = 8'h00;
  localparam logic [7:0] REG_RSVD_B   = 8'h01;
  localparam logic [7:0] REG_SYSCTL   = 8'h02;
  localparam logic [7:0] REG_SYSCTL2  = 8'h03;
  localparam logic [7:0] REG_IDENT_LO = 8'h80;
  localparam logic [7:0] REG_VERSION  = 8'h81;
  localparam logic [7:0] REG_RSVD_C   = 8'h82;
  localparam logic [7:0] STATIC_LO    = 8'h38;
  localparam logic [7:0] STATIC_HI    = 8'h3f;
  localparam logic [7:0] SYSCTL_RST   = 8'h0f;
  localparam logic [7:0] SYSCTL2_RST  = 8'h00;
  localparam logic [7:0] SYSCTL_MASK  = 8'h7f;
  localparam logic [7:0] SYSCTL2_MASK = 8'h0f;
  localparam int         SOFT_RST_BIT = 7;

  // ***********************************************************
  // bit counting
  // ***********************************************************
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ADDR2 = 3'b010,
    ST_INDEX = 3'b011,
    ST_WRITE = 3'b100,
    ST_READ  = 3'b101,
    ST_GCALL = 3'b110,
    ST_SKIP  = 3'b111
  } link_state_e;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] control_second;
  } sysctl_s;

endpackage : i2c_port_pkg

// *** src/i2c_slave_register_port.sv ***
// two-wire slave port with address straps, general call and system registers
// assumes open-drain resolution of the data line outside; the serial clock
// is only driven by the master and may stop between frames

`timescale 1ns/1ns
`default_nettype none

module i2c_slave_register_port
  import i2c_port_pkg::*;
#(
  parameter logic [7:0] CHIP_IDENT_LO = 8'h5a, // arbitrary value
  parameter logic [7:0] VERSION_VALUE = 8'h3c, // arbitrary value
  parameter logic [1:0] TEN_BIT_HIGH  = 2'b00
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       serial_clock_line_i,
  input  wire logic       serial_data_line_i,
  input  wire logic [1:0] addr_strap_i,
  output logic            serial_data_line_o,
  output logic            serial_data_line_oe_o,
  output sysctl_s         system_regs_o,
  output logic            device_reset_o,
  output logic [1:0]      addr_bits_o,
  output logic            busy_o
);

  // ***********************************************************
  // link clock domain
  // ***********************************************************
  // initial values stand in for a reset, since the link clock may be idle
  logic link_bit = 1'b0;
  logic link_tgl = 1'b0;

  always_ff @(posedge serial_clock_line_i) begin
    link_bit <= serial_data_line_i;
    link_tgl <= ~link_tgl;
  end

  // ***********************************************************
  // synchronisers into the system domain
  // ***********************************************************
  logic       scl_m;
  logic       scl_s;
  logic       sda_m;
  logic       sda_s;
  logic       tgl_m;
  logic       tgl_s;
  logic [1:0] strap_m;
  logic [1:0] strap_s;
  logic       scl_p;
  logic       sda_p;
  logic       tgl_p;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      tgl_m <= 1'b0;
      tgl_s <= 1'b0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      tgl_p <= 1'b0;
    end else begin
      scl_m <= serial_clock_line_i;
      scl_s <= scl_m;
      sda_m <= serial_data_line_i;
      sda_s <= sda_m;
      tgl_m <= link_tgl;
      tgl_s <= tgl_m;
      scl_p <= scl_s;
      sda_p <= sda_s;
      tgl_p <= tgl_s;
    end
  end

  // straps stay unreset so that the value is valid at reset release
  always_ff @(posedge sys_clk_i) begin
    strap_m <= addr_strap_i;
    strap_s <= strap_m;
  end

  // ***********************************************************
  // bus conditions
  // ***********************************************************
  logic start_c;
  logic stop_c;
  logic scl_fall;
  logic rx_evt;
  logic rx_bit;

  assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_fall = scl_p & ~scl_s;
  // link_bit is stable for the rest of the clock period once the toggle lands
  assign rx_evt   = tgl_s ^ tgl_p;
  assign rx_bit   = link_bit;

  // ***********************************************************
  // address and register helpers
  // ***********************************************************
  link_state_e st;
  link_state_e nxt;
  logic [3:0]  bitn;
  logic [7:0]  shift;
  logic [7:0]  rx_byte;
  logic [7:0]  idx;
  logic [7:0]  next_idx;
  logic [7:0]  txsr;
  logic        ack_en;
  logic        ten_hit;
  logic [1:0]  addr_bits;
  logic [7:0]  own_addr;
  logic        hit7;
  logic        ten1;
  logic        wr_en;
  logic        gc_evt;
  logic        gc_valid;
  logic [7:0]  ctl;
  logic [7:0]  ctl2;
  logic        dev_rst;
  logic        relatch;

  assign rx_byte  = {shift[6:0], rx_bit};
  assign own_addr = ADDR_BASE + {5'h00, addr_bits, 1'b0};
  assign hit7     = rx_byte[7:1] == own_addr[7:1];
  assign ten1     = rx_byte[7:1] == {TEN_PREFIX, TEN_BIT_HIGH};
  assign gc_valid = (rx_byte == GC_RESET) || (rx_byte == GC_LATCH);

  function automatic logic inc_ok(input logic [7:0] a);
    inc_ok = !((a >= STATIC_LO) && (a <= STATIC_HI));
  endfunction : inc_ok

  assign next_idx = inc_ok(idx) ? idx + 8'h01 : idx;

  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input logic [7:0] c,
                                        input logic [7:0] c2);
    unique case (a)
      REG_SYSCTL:   rd_reg = c;
      REG_SYSCTL2:  rd_reg = c2;
      REG_IDENT_LO: rd_reg = CHIP_IDENT_LO;
      REG_VERSION:  rd_reg = VERSION_VALUE;
      default:      rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // ***********************************************************
  // protocol engine
  // ***********************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st      <= ST_IDLE;
      nxt     <= ST_IDLE;
      bitn    <= 4'h0;
      shift   <= 8'h00;
      idx     <= 8'h00;
      txsr    <= 8'h00;
      ack_en  <= 1'b0;
      ten_hit <= 1'b0;
    end else if (stop_c) begin
      st      <= ST_IDLE;
      bitn    <= 4'h0;
      ack_en  <= 1'b0;
      ten_hit <= 1'b0;
    end else if (start_c) begin
      st     <= ST_ADDR;
      bitn   <= 4'h0;
      ack_en <= 1'b0;
    end else if (rx_evt && st != ST_IDLE) begin
      shift <= rx_byte;
      if (bitn == BIT_ACK) begin
        bitn   <= 4'h0;
        ack_en <= 1'b0;
        st     <= nxt;
        if (st == ST_WRITE) begin
          idx <= next_idx;
        end
        if (st == ST_READ) begin
          if (rx_bit) begin
            st <= ST_SKIP; // master declined more data
          end else begin
            idx  <= next_idx;
            txsr <= rd_reg(next_idx, ctl, ctl2);
          end
        end else if (nxt == ST_READ) begin
          txsr <= rd_reg(idx, ctl, ctl2);
        end
      end else begin
        bitn <= bitn + 4'h1;
        if (st == ST_READ) begin
          txsr <= {txsr[6:0], 1'b0};
        end
        if (bitn == BIT_LAST) begin
          unique case (st)
            ST_ADDR: begin
              if (hit7) begin
                ack_en <= 1'b1;
                nxt    <= rx_byte[0] ? ST_READ : ST_INDEX;
              end else if (rx_byte == GCALL_ADDR) begin
                ack_en <= 1'b1;
                nxt    <= ST_GCALL;
              end else if (ten1 && !rx_byte[0]) begin
                ack_en <= 1'b1;
                nxt    <= ST_ADDR2;
              end else if (ten1 && ten_hit) begin
                ack_en <= 1'b1;
                nxt    <= ST_READ;
              end else begin
                ack_en <= 1'b0;
                nxt    <= ST_SKIP;
              end
            end
            ST_ADDR2: begin
              ack_en  <= rx_byte == {1'b0, own_addr[7:1]};
              ten_hit <= rx_byte == {1'b0, own_addr[7:1]};
              nxt     <= (rx_byte == {1'b0, own_addr[7:1]}) ? ST_INDEX : ST_SKIP;
            end
            ST_INDEX: begin
              idx    <= rx_byte;
              ack_en <= 1'b1;
              nxt    <= ST_WRITE;
            end
            ST_WRITE: begin
              ack_en <= 1'b1;
              nxt    <= ST_WRITE;
            end
            ST_GCALL: begin
              ack_en <= gc_valid;
              nxt    <= ST_SKIP;
            end
            ST_READ: begin
              ack_en <= 1'b0;
              nxt    <= ST_READ;
            end
            ST_SKIP: begin
              ack_en <= 1'b0;
              nxt    <= ST_SKIP;
            end
            ST_IDLE: begin
              ack_en <= 1'b0;
              nxt    <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ***********************************************************
  // data line drive, changed on a clock fall and released on start or stop
  // ***********************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || start_c || stop_c) begin
      serial_data_line_oe_o <= 1'b0;
    end else if (scl_fall) begin
      if (bitn == BIT_ACK) begin
        serial_data_line_oe_o <= ack_en;
      end else begin
        serial_data_line_oe_o <= (st == ST_READ) && !txsr[7];
      end
    end
  end

  assign serial_data_line_o = 1'b0;
  // ***********************************************************
  // system registers
  // ***********************************************************
  assign wr_en  = rx_evt && !start_c && !stop_c && bitn == BIT_LAST && st == ST_WRITE;
  assign gc_evt = rx_evt && !start_c && !stop_c && bitn == BIT_LAST && st == ST_GCALL;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || dev_rst) begin
      ctl  <= SYSCTL_RST;
      ctl2 <= SYSCTL2_RST;
    end else if (wr_en) begin
      if (idx == REG_SYSCTL) begin
        ctl <= rx_byte & SYSCTL_MASK;
      end
      if (idx == REG_SYSCTL2) begin
        ctl2 <= rx_byte & SYSCTL2_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dev_rst <= 1'b0;
    end else begin
      dev_rst <= (wr_en && idx == REG_SYSCTL && rx_byte[SOFT_RST_BIT]) ||
                 (gc_evt && rx_byte == GC_RESET);
    end
  end

  // straps are taken in the first cycle after reset release
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      relatch <= 1'b1;
    end else begin
      relatch <= gc_evt && gc_valid;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      addr_bits <= 2'b00;
    end else if (relatch) begin
      addr_bits <= strap_s;
    end
  end

  assign system_regs_o  = '{control: ctl, control_second: ctl2};
  assign device_reset_o = dev_rst;
  assign addr_bits_o    = addr_bits;
  assign busy_o         = st != ST_IDLE;
endmodule : i2c_slave_register_port
`default_nettype wire

// *** tb/i2c_port_assertions.sv ***
// checker for the two-wire slave register port
// assumes it is bound to the port module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module i2c_port_assertions
  import i2c_port_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       serial_clock_line_i,
  input wire logic       serial_data_line_i,
  input wire logic       serial_data_line_o,
  input wire logic       serial_data_line_oe_o,
  input wire sysctl_s    system_regs_o,
  input wire logic       device_reset_o,
  input wire logic [1:0] addr_bits_o,
  input wire logic       busy_o
);
  // ****************************************
  // bus conditions and register side
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence start_seen;
    $fell(serial_data_line_i) && serial_clock_line_i;
  endsequence
  sequence stop_seen;
    $rose(serial_data_line_i) && serial_clock_line_i;
  endsequence
  AST_START_BUSY: assert property (start_seen |-> ##[1:8] busy_o)
    else $error("start not taken");
  AST_STOP_IDLE: assert property (stop_seen |-> ##[1:8] !busy_o)
    else $error("stop not taken");
  AST_IDLE_QUIET: assert property ((!busy_o) [*3] |-> !serial_data_line_oe_o)
    else $error("line driven while idle");
  AST_OE_SCL_LOW: assert property (
    $changed(serial_data_line_oe_o) |-> !serial_clock_line_i)
    else $error("drive changed with clock high");
  AST_OD_LOW: assert property (!serial_data_line_o)
    else $error("data output not low");
  AST_STRAP_HOLD: assert property (
    !busy_o && !$past(busy_o) && !$past(rst_i, 2) |-> $stable(addr_bits_o))
    else $error("address bits moved while idle");
  AST_RST_PULSE: assert property (device_reset_o |=> !device_reset_o)
    else $error("reset pulse too long");
  AST_RST_REGS: assert property (
    device_reset_o |-> ##[0:2] system_regs_o == {SYSCTL_RST, SYSCTL2_RST})
    else $error("registers not reset");
  AST_CTRL2_RSVD: assert property (system_regs_o.control_second[7:4] == 4'h0)
    else $error("reserved bits set");
  AST_REGS_IDLE: assert property (
    !busy_o && !$past(busy_o) |-> $stable(system_regs_o))
    else $error("registers moved while idle");
endmodule : i2c_port_assertions
`default_nettype wire

// *** tb/i2c_master_model.sv ***
// bus master model: open-drain data, clock driven only inside frames
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // ****************************************
  // bus phases, 125 ns bit time
  // ****************************************
  localparam int LO = 63;
  localparam int HI = 62;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // non-blocking updates keep pin edges that land on a system clock edge race-free
  task automatic start();
    sda_oe_o <= 1'b1;
    #HI;
    scl_o <= 1'b0;
  endtask : start
  // data moves 10 ns after the fall, well clear of the rise
  task automatic bit_x(input logic b, output logic r);
    #10;
    sda_oe_o <= ~b;
    #(LO - 10);
    scl_o <= 1'b1;
    r = sda_i;
    #HI;
    scl_o <= 1'b0;
  endtask : bit_x
  task automatic restart();
    #10;
    sda_oe_o <= 1'b0;
    #(LO - 10);
    scl_o <= 1'b1;
    #HI;
    start();
  endtask : restart
  task automatic stop();
    #10;
    sda_oe_o <= 1'b1;
    #(LO - 10);
    scl_o <= 1'b1;
    #HI;
    sda_oe_o <= 1'b0;
    #HI;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic nack,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(nack, r);
    ack = ~r;
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the two-wire slave register port
// assumes the master model and the checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import i2c_port_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic [1:0] strap     = 2'b10;
  logic       scl;
  logic       m_oe;
  logic       oe;
  logic       dres;
  logic       busy;
  logic [1:0] abits;
  sysctl_s    regs;
  logic [7:0] q;
  logic       a;
  int         fails     = 0;
  int         compares  = 0;
  int         pulses    = 0;
  wire logic  sda = ~(m_oe | oe);
  always #4 sys_clk_i = ~sys_clk_i;
  // reset pulses are counted so that each source is seen to fire exactly once
  always @(posedge sys_clk_i) begin
    if (dres === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  i2c_master_model m (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
  i2c_slave_register_port dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_clock_line_i(scl),
    .serial_data_line_i(sda), .addr_strap_i(strap), .serial_data_line_o(),
    .serial_data_line_oe_o(oe), .system_regs_o(regs), .device_reset_o(dres),
    .addr_bits_o(abits), .busy_o(busy));
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic [7:0] d, input logic ack);
    m.xfer(d, 1'b1, q, a);
    chk(16'(a), 16'(ack));
  endtask : wb
  task automatic probe(input logic [7:0] ad, input logic ack);
    m.start();
    wb(ad, ack);
    m.stop();
    chk(16'(busy), 16'h0000);
  endtask : probe
  task automatic gc(input logic [7:0] cmd, input logic ack);
    m.start();
    wb(GCALL_ADDR, 1'b1);
    wb(cmd, ack);
    m.stop();
  endtask : gc
  task automatic wr2(input logic [7:0] ad, idx, d0, d1);
    m.start();
    wb(ad, 1'b1);
    wb(idx, 1'b1);
    wb(d0, 1'b1);
    wb(d1, 1'b1);
    m.stop();
  endtask : wr2
  task automatic rd2(input logic [7:0] ad, idx, e0, e1);
    m.start();
    wb(ad, 1'b1);
    wb(idx, 1'b1);
    m.restart();
    wb(ad | 8'h01, 1'b1);
    m.xfer(8'hff, 1'b0, q, a);
    chk(16'(q), 16'(e0));
    m.xfer(8'hff, 1'b1, q, a);
    chk(16'(q), 16'(e1));
    m.stop();
  endtask : rd2
  // ten-bit frame: prefix byte, low address byte, index, then prefix read
  task automatic rd10(input logic [7:0] lo, idx, e0);
    m.start();
    wb({TEN_PREFIX, 3'b000}, 1'b1);
    wb(lo, 1'b1);
    wb(idx, 1'b1);
    m.restart();
    wb({TEN_PREFIX, 3'b001}, 1'b1);
    m.xfer(8'hff, 1'b1, q, a);
    chk(16'(q), 16'(e0));
    m.stop();
  endtask : rd10
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    chk(16'(abits), 16'h0002);
    rd2(8'h88, REG_SYSCTL, SYSCTL_RST, SYSCTL2_RST);
    rd2(8'h88, REG_IDENT_LO, 8'h5a, 8'h3c);
    wr2(8'h88, REG_VERSION, 8'hff, 8'hff);
    rd2(8'h88, REG_VERSION, 8'h3c, 8'h00);
    wr2(8'h88, REG_SYSCTL, 8'h05, 8'hfa);
    chk(regs, 16'h050a);
    rd2(8'h88, REG_SYSCTL, 8'h05, 8'h0a);
    $display("register access test done");
    @(posedge sys_clk_i);
    strap <= 2'b01;
    repeat (8) @(posedge sys_clk_i);
    probe(8'h86, 1'b0);
    probe(8'h88, 1'b1);
    gc(8'h07, 1'b0);
    chk(16'(abits), 16'h0002);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk_i);
      strap <= s[1:0];
      repeat (8) @(posedge sys_clk_i);
      gc(GC_LATCH, 1'b1);
      probe(ADDR_BASE + 8'(2 * s), 1'b1);
      chk(16'(abits), 16'(s[1:0]));
    end
    chk(regs, 16'h050a);
    chk(16'(pulses), 16'h0000);
    rd10(8'h45, REG_SYSCTL2, 8'h0a);
    $display("address test done");
    wr2(8'h8a, REG_SYSCTL, 8'h80, 8'h03);
    chk(regs, {SYSCTL_RST, 8'h03});
    chk(16'(pulses), 16'h0001);
    @(posedge sys_clk_i);
    strap <= 2'b00;
    repeat (8) @(posedge sys_clk_i);
    gc(GC_RESET, 1'b1);
    chk(16'(abits), 16'h0000);
    chk(regs, {SYSCTL_RST, SYSCTL2_RST});
    chk(16'(pulses), 16'h0002);
    rd2(8'h84, REG_SYSCTL, SYSCTL_RST, SYSCTL2_RST);
    $display("reset test done");
    end_of_test();
  end
  // bus traffic takes under 100 us; the limit leaves ample margin
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule : testbench
bind i2c_slave_register_port i2c_port_assertions chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_clock_line_i(serial_clock_line_i),
  .serial_data_line_i(serial_data_line_i), .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe_o(serial_data_line_oe_o), .system_regs_o(system_regs_o),
  .device_reset_o(device_reset_o), .addr_bits_o(addr_bits_o), .busy_o(busy_o));
`default_nettype wire
